// File: rtl/tsc_conv_if.sv
`timescale 1ns/100ps
interface tsc_conv_if;
  logic halt;
  logic os_req;
  logic [1:0] period_sel;
  logic conv_active;
  logic conv_done;
  modport ctrl (output halt, output os_req, output period_sel,
                input conv_active, input conv_done);
  modport sched (input halt, input os_req, input period_sel,
                 output conv_active, output conv_done);
endinterface : tsc_conv_if

// File: rtl/tsc_conv_sched.sv
`timescale 1ns/100ps
module tsc_conv_sched #(
  parameter int ACTIVE_CYC = tsc_pkg::ACTIVE_CYC,
  parameter int PERIOD0_CYC = tsc_pkg::PERIOD0_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Control from the main block.
  tsc_conv_if.sched cv
);
  typedef enum logic [1:0] {TSC_IDLE, TSC_ACTIVE, TSC_STANDBY} tsc_cstate_t;

  tsc_cstate_t state_reg;
  logic [tsc_pkg::CNT_W-1:0] cnt_reg;
  logic oneshot_reg;
  logic [tsc_pkg::CNT_W-1:0] period_cyc;

  // Longer periods are 2, 4 and 8 times the shortest one.
  assign period_cyc = tsc_pkg::CNT_W'(PERIOD0_CYC) << cv.period_sel;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= TSC_IDLE;
      cnt_reg <= '0;
      oneshot_reg <= 1'b0;
      cv.conv_active <= 1'b0;
      cv.conv_done <= 1'b0;
    end else begin
      cv.conv_done <= 1'b0;
      case (state_reg)
        TSC_IDLE: begin
          cnt_reg <= '0;
          if (!cv.halt || cv.os_req) begin
            state_reg <= TSC_ACTIVE;
            oneshot_reg <= cv.halt;
            cv.conv_active <= 1'b1;
          end
        end
        TSC_ACTIVE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == tsc_pkg::CNT_W'(ACTIVE_CYC - 1)) begin
            cv.conv_done <= 1'b1;
            cv.conv_active <= 1'b0;
            // A one-shot always returns to the halted state after its conversion.
            state_reg <= (oneshot_reg || cv.halt) ? TSC_IDLE : TSC_STANDBY;
          end
        end
        TSC_STANDBY: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cv.halt) begin
            state_reg <= TSC_IDLE;
          end else if (cnt_reg >= period_cyc - 1'b1) begin
            state_reg <= TSC_ACTIVE;
            cnt_reg <= '0;
            oneshot_reg <= 1'b0;
            cv.conv_active <= 1'b1;
          end
        end
        default: state_reg <= TSC_IDLE;
      endcase
    end
  end
endmodule : tsc_conv_sched

// File: rtl/tsc_pkg.sv
package tsc_pkg;
  // Clock and timing.
  localparam real CLK_HZ = 100.0e6;
  localparam real T_ACTIVE_MS = 5.5;
  localparam real T_PERIOD0_MS = 27.5;
  localparam real T_TIMEOUT_MS = 25.0;
  localparam int ACTIVE_CYC = int'(T_ACTIVE_MS * 1.0e-3 * CLK_HZ);
  localparam int PERIOD0_CYC = int'(T_PERIOD0_MS * 1.0e-3 * CLK_HZ);
  localparam int TIMEOUT_CYC = int'(T_TIMEOUT_MS * 1.0e-3 * CLK_HZ);
  localparam int CNT_W = 32;

  // Bus codes.
  localparam logic [7:0] ARA_BYTE = 8'h19;
  localparam logic [7:0] GC_BYTE = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [7:0] HS_MASK = 8'hF8;
  localparam logic [7:0] HS_CODE = 8'h08;
  localparam logic [7:0] PTR_RST = 8'h00;

  // Configuration field positions and reset values.
  localparam int CFG_TRIG = 15;
  localparam int CFG_PER_HI = 14;
  localparam int CFG_PER_LO = 13;
  localparam int CFG_FQ_HI = 12;
  localparam int CFG_FQ_LO = 11;
  localparam int CFG_POL = 10;
  localparam int CFG_TM = 9;
  localparam int CFG_HALT = 8;
  localparam logic [7:0] CFG_LOW_BYTE = 8'hFF;
  localparam logic [1:0] PER_RST = 2'h0;
  localparam logic [1:0] FQ_RST = 2'h0;

  // Limit rail values that disable the alert.
  localparam logic [11:0] TLOW_RAIL = 12'h800;
  localparam logic [11:0] THIGH_RAIL = 12'h7FF;
endpackage : tsc_pkg

// File: rtl/tsc_top.sv
`timescale 1ns/100ps
module tsc_top #(
  parameter int ACTIVE_CYC = tsc_pkg::ACTIVE_CYC,
  parameter int PERIOD0_CYC = tsc_pkg::PERIOD0_CYC,
  parameter int TIMEOUT_CYC = tsc_pkg::TIMEOUT_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Two-wire bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic hs_mode,
  // Address and write path.
  input wire logic [6:0] dev_addr,
  input wire logic ptr_wr,
  input wire logic [7:0] ptr_wdata,
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_wdata,
  output logic [7:0] rd_ptr,
  input wire logic [15:0] rd_word,
  output logic [15:0] cfg_rdata,
  output logic gc_reset,
  // Conversion and limits.
  input wire logic [11:0] temp_in,
  input wire logic [11:0] tlow,
  input wire logic [11:0] thigh,
  output logic conv_active,
  output logic conv_done,
  // Alert pin.
  output logic alert_pin
);
  typedef enum logic [2:0] {
    TSC_IDLE, TSC_ADDR, TSC_ACK, TSC_TX, TSC_HACK, TSC_HACK2, TSC_GC, TSC_WAIT
  } tsc_bstate_t;

  tsc_conv_if cv ();

  tsc_conv_sched #(
    .ACTIVE_CYC(ACTIVE_CYC),
    .PERIOD0_CYC(PERIOD0_CYC)
  ) u_sched (
    .clk(clk),
    .arst_n(arst_n),
    .cv(cv)
  );

  // Pin synchronisers and edge history.
  logic scl_m_reg, scl_s_reg, scl_d_reg;
  logic sda_m_reg, sda_s_reg, sda_d_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s_reg && !scl_d_reg;
  assign scl_fall = !scl_s_reg && scl_d_reg;
  assign bus_start = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
  assign bus_stop = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;

  // Configuration state.
  logic halt_reg, tm_reg, pol_reg;
  logic [1:0] fq_reg, per_reg;
  logic os_reg, gc_hit;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_reg <= 1'b0;
      tm_reg <= 1'b0;
      pol_reg <= 1'b0;
      fq_reg <= tsc_pkg::FQ_RST;
      per_reg <= tsc_pkg::PER_RST;
      os_reg <= 1'b0;
      rd_ptr <= tsc_pkg::PTR_RST;
    end else begin
      os_reg <= 1'b0;
      if (gc_hit) begin
        halt_reg <= 1'b0;
        tm_reg <= 1'b0;
        pol_reg <= 1'b0;
        fq_reg <= tsc_pkg::FQ_RST;
        per_reg <= tsc_pkg::PER_RST;
        rd_ptr <= tsc_pkg::PTR_RST;
      end else begin
        if (ptr_wr) begin
          rd_ptr <= ptr_wdata;
        end
        if (cfg_wr) begin
          halt_reg <= cfg_wdata[tsc_pkg::CFG_HALT];
          tm_reg <= cfg_wdata[tsc_pkg::CFG_TM];
          pol_reg <= cfg_wdata[tsc_pkg::CFG_POL];
          fq_reg <= cfg_wdata[tsc_pkg::CFG_FQ_HI:tsc_pkg::CFG_FQ_LO];
          per_reg <= cfg_wdata[tsc_pkg::CFG_PER_HI:tsc_pkg::CFG_PER_LO];
          os_reg <= cfg_wdata[tsc_pkg::CFG_TRIG] && cfg_wdata[tsc_pkg::CFG_HALT];
        end
      end
    end
  end

  assign cv.halt = halt_reg;
  assign cv.os_req = os_reg;
  assign cv.period_sel = per_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= {8'h00, tsc_pkg::CFG_LOW_BYTE};
      conv_active <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      // The trigger bit is a strobe and is never stored.
      cfg_rdata <= {1'b0, per_reg, fq_reg, pol_reg, tm_reg, halt_reg,
                    tsc_pkg::CFG_LOW_BYTE};
      conv_active <= cv.conv_active;
      conv_done <= cv.conv_done;
    end
  end

  // Alert logic.
  logic alert_reg, cause_high_reg, watch_low_reg;
  logic [2:0] fcnt_reg;
  logic rd_clear, ara_win;
  logic hi_hit, lo_hit, rails, match;
  logic [2:0] need;
  assign hi_hit = $signed(temp_in) >= $signed(thigh);
  assign lo_hit = $signed(temp_in) < $signed(tlow);
  assign rails = (tlow == tsc_pkg::TLOW_RAIL) && (thigh == tsc_pkg::THIGH_RAIL);
  assign need = {1'b0, fq_reg} + 3'h1;
  assign match = tm_reg ? (watch_low_reg ? lo_hit : hi_hit)
                        : (alert_reg ? lo_hit : hi_hit);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_reg <= 1'b0;
      cause_high_reg <= 1'b1;
      watch_low_reg <= 1'b0;
      fcnt_reg <= 3'h0;
    end else if (gc_hit || cfg_wr) begin
      alert_reg <= 1'b0;
      watch_low_reg <= 1'b0;
      fcnt_reg <= 3'h0;
    end else begin
      if (tm_reg && halt_reg) begin
        alert_reg <= 1'b0;
        watch_low_reg <= 1'b0;
      end else if (tm_reg && alert_reg && (rd_clear || ara_win)) begin
        alert_reg <= 1'b0;
        watch_low_reg <= !watch_low_reg;
      end
      // A conversion landing on a clear cycle still counts, and its set wins.
      if (cv.conv_done && !(tm_reg && alert_reg && !rd_clear && !ara_win)) begin
        if (!match || rails) begin
          fcnt_reg <= 3'h0;
        end else if (fcnt_reg + 3'h1 >= need) begin
          fcnt_reg <= 3'h0;
          alert_reg <= tm_reg ? 1'b1 : !alert_reg;
          if (tm_reg) begin
            cause_high_reg <= !watch_low_reg;
          end else if (!alert_reg) begin
            cause_high_reg <= 1'b1;
          end
        end else begin
          fcnt_reg <= fcnt_reg + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_pin <= 1'b1;
    end else begin
      alert_pin <= pol_reg ? alert_reg : !alert_reg;
    end
  end

  // Two-wire target.
  tsc_bstate_t st_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg, tx_reg;
  logic [7:0] lsb_reg;
  logic drive_reg, first_reg, tx_next_reg, gc_next_reg, ara_reg, lsb_sent_reg;
  // Marks that a byte has begun, so the SCL fall right after START is not taken as its end.
  logic bit_seen_reg;
  logic [tsc_pkg::CNT_W-1:0] to_reg;
  logic timeout;
  assign timeout = to_reg >= tsc_pkg::CNT_W'(TIMEOUT_CYC - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      to_reg <= '0;
    end else if (st_reg != TSC_IDLE && (!scl_s_reg || drive_reg) && !timeout) begin
      to_reg <= to_reg + 1'b1;
    end else begin
      to_reg <= '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_mode <= 1'b0;
    end else if (bus_stop) begin
      hs_mode <= 1'b0;
    end else if (st_reg == TSC_ADDR && scl_fall && bit_reg == 3'h0 && first_reg && bit_seen_reg
                 && (sh_reg & tsc_pkg::HS_MASK) == tsc_pkg::HS_CODE) begin
      hs_mode <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= TSC_IDLE;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      lsb_reg <= 8'h00;
      drive_reg <= 1'b0;
      first_reg <= 1'b0;
      tx_next_reg <= 1'b0;
      gc_next_reg <= 1'b0;
      ara_reg <= 1'b0;
      lsb_sent_reg <= 1'b0;
      bit_seen_reg <= 1'b0;
      rd_clear <= 1'b0;
      ara_win <= 1'b0;
      gc_hit <= 1'b0;
    end else begin
      rd_clear <= 1'b0;
      ara_win <= 1'b0;
      gc_hit <= 1'b0;
      if (timeout || bus_stop) begin
        st_reg <= TSC_IDLE;
        drive_reg <= 1'b0;
      end else if (bus_start) begin
        st_reg <= TSC_ADDR;
        bit_reg <= 3'h0;
        bit_seen_reg <= 1'b0;
        drive_reg <= 1'b0;
        first_reg <= !hs_mode;
      end else begin
        case (st_reg)
          TSC_ADDR, TSC_GC: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda_s_reg};
              bit_reg <= bit_reg + 3'h1;
              bit_seen_reg <= 1'b1;
            end else if (scl_fall && bit_reg == 3'h0 && bit_seen_reg && st_reg == TSC_GC) begin
              if (sh_reg == tsc_pkg::GC_RESET_CMD) begin
                gc_hit <= 1'b1;
                drive_reg <= 1'b1;
                tx_next_reg <= 1'b0;
                gc_next_reg <= 1'b0;
                st_reg <= TSC_ACK;
              end else begin
                st_reg <= TSC_WAIT;
              end
            end else if (scl_fall && bit_reg == 3'h0 && bit_seen_reg) begin
              tx_next_reg <= 1'b0;
              gc_next_reg <= 1'b0;
              ara_reg <= 1'b0;
              lsb_sent_reg <= 1'b0;
              st_reg <= TSC_ACK;
              drive_reg <= 1'b1;
              if (sh_reg == {dev_addr, 1'b1}) begin
                tx_next_reg <= 1'b1;
                tx_reg <= rd_word[15:8];
                lsb_reg <= rd_word[7:0];
                rd_clear <= 1'b1;
              end else if (sh_reg == tsc_pkg::ARA_BYTE && tm_reg && alert_reg) begin
                tx_next_reg <= 1'b1;
                ara_reg <= 1'b1;
                tx_reg <= {dev_addr, cause_high_reg ? pol_reg : !pol_reg};
              end else if (sh_reg == tsc_pkg::GC_BYTE) begin
                gc_next_reg <= 1'b1;
              end else if (sh_reg != {dev_addr, 1'b0}) begin
                // Foreign addresses and the high-speed code get no acknowledge.
                drive_reg <= 1'b0;
                st_reg <= TSC_WAIT;
              end
            end
          end
          TSC_ACK: begin
            if (scl_fall) begin
              bit_reg <= 3'h0;
              bit_seen_reg <= 1'b0;
              if (tx_next_reg) begin
                st_reg <= TSC_TX;
                drive_reg <= !tx_reg[7];
              end else begin
                drive_reg <= 1'b0;
                st_reg <= gc_next_reg ? TSC_GC : TSC_WAIT;
              end
            end
          end
          TSC_TX: begin
            if (scl_rise && ara_reg && !drive_reg && !sda_s_reg) begin
              st_reg <= TSC_WAIT;
            end else if (scl_fall) begin
              bit_reg <= bit_reg + 3'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              if (bit_reg == 3'h7) begin
                drive_reg <= 1'b0;
                st_reg <= TSC_HACK;
              end else begin
                drive_reg <= !tx_reg[6];
              end
            end
          end
          TSC_HACK: begin
            if (scl_rise) begin
              if (ara_reg) begin
                ara_win <= 1'b1;
                st_reg <= TSC_WAIT;
              end else begin
                st_reg <= sda_s_reg ? TSC_WAIT : TSC_HACK2;
              end
            end
          end
          TSC_HACK2: begin
            if (scl_fall) begin
              bit_reg <= 3'h0;
              st_reg <= TSC_TX;
              tx_reg <= lsb_sent_reg ? rd_word[15:8] : lsb_reg;
              drive_reg <= lsb_sent_reg ? !rd_word[15] : !lsb_reg[7];
              lsb_sent_reg <= !lsb_sent_reg;
            end
          end
          TSC_WAIT: drive_reg <= 1'b0;
          default: st_reg <= TSC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o <= 1'b0;
      sda_oe_n <= 1'b1;
      gc_reset <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n <= !drive_reg;
      gc_reset <= gc_hit;
    end
  end
endmodule : tsc_top

// File: sim/tsc_host_model.sv
`timescale 1ns/100ps
module tsc_host_model (
  // Clock.
  input wire logic clk,
  // Bus wires.
  input wire logic dev_o,
  input wire logic dev_oe_n,
  output logic scl,
  output logic sda
);
  logic rel = 1'b1;
  initial scl = 1'b1;
  // Pulled-up wire: high unless some party pulls it low.
  assign sda = rel & (dev_oe_n | dev_o);

  // Ten clocks per high half bit and thirteen per low half keep the bus clock far above the time-out rate.
  task automatic half(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : half

  task automatic start;
    rel = 1'b1;
    half(10);
    scl = 1'b1;
    half(10);
    rel = 1'b0;
    half(10);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    half(3);
    rel = 1'b0;
    half(10);
    scl = 1'b1;
    half(10);
    rel = 1'b1;
    half(10);
  endtask : stop

  // Data moves only well inside the low phase, so it never looks like a start or stop.
  task automatic put_bit(input logic b);
    half(3);
    rel = b;
    half(10);
    scl = 1'b1;
    half(10);
    scl = 1'b0;
  endtask : put_bit

  task automatic get_bit(output logic b);
    half(3);
    rel = 1'b1;
    half(10);
    scl = 1'b1;
    half(10);
    b = sda;
    scl = 1'b0;
  endtask : get_bit

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask : wr_byte

  task automatic rd_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!ack);
  endtask : rd_byte
endmodule : tsc_host_model

// File: sim/tsc_top_properties.sv
`timescale 1ns/100ps
module tsc_top_properties #(
  parameter int ACTIVE_CYC = 20,
  parameter int PERIOD0_CYC = 60,
  parameter int TIMEOUT_CYC = 200
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_n,
  input wire logic hs_mode,
  // Pointer and configuration.
  input wire logic ptr_wr,
  input wire logic [7:0] ptr_wdata,
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_wdata,
  input wire logic [7:0] rd_ptr,
  input wire logic [15:0] cfg_rdata,
  input wire logic gc_reset,
  // Conversion and alert.
  input wire logic conv_active,
  input wire logic conv_done,
  input wire logic alert_pin
);
  int act_cnt;
  int low_cnt;
  int wr_age;

  // A trigger write needs a few cycles to reach the scheduler, so halt is judged after that.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_cnt <= 0;
      low_cnt <= 0;
      wr_age <= 8;
    end else begin
      act_cnt <= conv_active ? act_cnt + 1 : 0;
      low_cnt <= scl_i ? 0 : low_cnt + 1;
      wr_age <= cfg_wr ? 0 : (wr_age < 8 ? wr_age + 1 : wr_age);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  act_len_a: assert property ($fell(conv_active) |-> act_cnt == ACTIVE_CYC)
    else $error("conversion length wrong");
  done_pulse_a: assert property (conv_done |=> !conv_done)
    else $error("conversion done not a pulse");
  halt_idle_a: assert property (cfg_rdata[8] && !conv_active && wr_age > 4 |=> !conv_active)
    else $error("conversion started while halted");
  cfg_read_a: assert property (cfg_wr |-> ##2 cfg_rdata == {1'b0, $past(cfg_wdata[14:8], 2), 8'hFF})
    else $error("configuration readback wrong");
  mode_clear_a: assert property (cfg_wr && !conv_done && !$past(conv_done) |-> ##2 alert_pin == !cfg_rdata[10])
    else $error("alert not cleared by mode write");
  gc_reset_a: assert property (gc_reset |-> ##[1:3] (cfg_rdata == 16'h00FF && rd_ptr == 8'h00))
    else $error("general call did not restore state");
  ptr_keep_a: assert property (ptr_wr |=> rd_ptr == $past(ptr_wdata))
    else $error("pointer not stored");
  hs_stop_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[2:6] !hs_mode)
    else $error("high speed kept after stop");
  timeout_a: assert property (low_cnt > TIMEOUT_CYC + 8 |-> sda_oe_n)
    else $error("data line held after time-out");
endmodule : tsc_top_properties

bind tsc_top tsc_top_properties #(.ACTIVE_CYC(ACTIVE_CYC), .PERIOD0_CYC(PERIOD0_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC)) props (.clk(clk), .arst_n(arst_n), .scl_i(scl_i),
  .sda_i(sda_i), .sda_oe_n(sda_oe_n), .hs_mode(hs_mode), .ptr_wr(ptr_wr),
  .ptr_wdata(ptr_wdata), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .rd_ptr(rd_ptr),
  .cfg_rdata(cfg_rdata), .gc_reset(gc_reset), .conv_active(conv_active),
  .conv_done(conv_done), .alert_pin(alert_pin));

// File: sim/tsc_top_test.sv
`timescale 1ns/100ps
module tsc_top_test;
  localparam int PER0 = 60;
  localparam logic [6:0] ADDR = 7'h4A;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, sda, sda_o, sda_oe_n, hs_mode, gc_reset, conv_active, conv_done, alert_pin;
  logic ptr_wr = 1'b0;
  logic cfg_wr = 1'b0;
  logic ack;
  logic [7:0] ptr_wdata = 8'h00;
  logic [7:0] rd_ptr, b0, b1;
  logic [15:0] cfg_wdata = 16'h00FF;
  logic [15:0] cfg_rdata;
  logic [11:0] temp_in = 12'h180;
  logic [11:0] tlow = 12'h100;
  logic [11:0] thigh = 12'h200;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, m;

  initial begin
    forever #5 clk = ~clk;
  end

  tsc_top #(.ACTIVE_CYC(20), .PERIOD0_CYC(PER0), .TIMEOUT_CYC(200)) uut (.clk(clk),
    .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .hs_mode(hs_mode), .dev_addr(ADDR), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .rd_ptr(rd_ptr), .rd_word({rd_ptr, ~rd_ptr}),
    .cfg_rdata(cfg_rdata), .gc_reset(gc_reset), .temp_in(temp_in), .tlow(tlow),
    .thigh(thigh), .conv_active(conv_active), .conv_done(conv_done), .alert_pin(alert_pin));
  tsc_host_model host (.clk(clk), .dev_o(sda_o), .dev_oe_n(sda_oe_n), .scl(scl), .sda(sda));

  task automatic stop_test;
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr_cfg(input logic [15:0] v);
    cfg_wdata = v;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
  endtask : wr_cfg

  task automatic to_done;
    for (int k = 0; k < 1000 && conv_done !== 1'b1; k++) tick(1);
    tick(1);
  endtask : to_done

  task automatic count(input int len, output int a, output int d);
    a = 0;
    d = 0;
    repeat (len) begin
      a += int'(conv_active === 1'b1);
      d += int'(conv_done === 1'b1);
      tick(1);
    end
  endtask : count

  // Counts conversions until the alert pin reaches the given level.
  task automatic watch(input logic lvl, input int maxc, output int got);
    got = 0;
    for (int i = 0; i < maxc * PER0 + 10 && alert_pin !== lvl; i++) begin
      got += int'(conv_done === 1'b1);
      tick(1);
    end
  endtask : watch

  task automatic ara(output logic a, output logic [7:0] d);
    d = 8'h00;
    host.start();
    host.wr_byte(tsc_pkg::ARA_BYTE, a);
    if (a) host.rd_byte(d, 1'b0);
    host.stop();
  endtask : ara

  initial begin
    tick(2);
    check(cfg_rdata, 16'h00FF);
    check({alert_pin, sda_oe_n, hs_mode}, 3'b110);
    arst_n = 1'b1;
    tick(2);
    ptr_wdata = 8'h03;
    ptr_wr = 1'b1;
    tick(1);
    ptr_wr = 1'b0;
    host.start();
    host.wr_byte({ADDR, 1'b1}, ack);
    host.rd_byte(b0, 1'b1);
    host.rd_byte(b1, 1'b0);
    tick(8);
    check(sda_oe_n, 1'b1);
    host.stop();
    check({ack, b0, b1}, {1'b1, 8'h03, 8'hFC});
    check(rd_ptr, 8'h03);
    for (int s = 0; s < 4; s++) begin
      wr_cfg({1'b0, s[1:0], 5'h00, 8'hFF});
      to_done();
      to_done();
      count(0, m, n);
      for (n = 1; n < 2000 && conv_done !== 1'b1; n++) tick(1);
      check(24'(n), 24'(PER0 << s));
    end
    wr_cfg(16'h01FF);
    tick(100);
    count(200, n, m);
    check(24'(n), 24'h000000);
    wr_cfg(16'h81FF);
    count(300, n, m);
    check({n[7:0], m[7:0]}, {8'h14, 8'h01});
    check(cfg_rdata, 16'h01FF);
    wr_cfg(16'h0AFF);
    tick(3);
    check(alert_pin, 1'b1);
    temp_in = 12'h300;
    watch(1'b0, 4, n);
    check({n[7:0], alert_pin}, {8'h02, 1'b0});
    ara(ack, b0);
    check({ack, b0}, {1'b1, ADDR, 1'b0});
    check(alert_pin, 1'b1);
    temp_in = 12'h050;
    watch(1'b0, 4, n);
    check({n[7:0], alert_pin}, {8'h02, 1'b0});
    ara(ack, b0);
    check({ack, b0, alert_pin}, {1'b1, ADDR, 2'b11});
    temp_in = 12'h180;
    wr_cfg(16'h04FF);
    tick(3);
    check(alert_pin, 1'b0);
    temp_in = 12'h300;
    watch(1'b1, 3, n);
    check({n[7:0], alert_pin}, {8'h01, 1'b1});
    ara(ack, b0);
    check({ack, alert_pin}, 2'b01);
    temp_in = 12'h050;
    watch(1'b0, 3, n);
    check({n[7:0], alert_pin}, {8'h01, 1'b0});
    tlow = 12'h800;
    thigh = 12'h7FF;
    temp_in = 12'h7FF;
    watch(1'b1, 3, n);
    check(alert_pin, 1'b0);
    tlow = 12'h100;
    thigh = 12'h200;
    host.start();
    host.wr_byte(tsc_pkg::GC_BYTE, b0[0]);
    host.wr_byte(tsc_pkg::GC_RESET_CMD, ack);
    host.stop();
    check({b0[0], ack, cfg_rdata, rd_ptr}, {2'b11, 16'h00FF, 8'h00});
    host.start();
    host.wr_byte(8'h0B, ack);
    tick(2);
    check({ack, hs_mode}, 2'b01);
    host.stop();
    tick(8);
    check(hs_mode, 1'b0);
    host.start();
    host.wr_byte({ADDR, 1'b1}, ack);
    tick(100);
    check({ack, sda_oe_n}, 2'b10);
    tick(200);
    check(sda_oe_n, 1'b1);
    host.stop();
    stop_test();
  end
endmodule : tsc_top_test
